/* dct_top.sv */
// Module: two 8-bit timers with two compare channels each, APB register slave
// Function
// R01: Counter steps on prescaled tick, divide 1..128
// R02: Start bit runs counter, zero freezes it
// R03: Free mode wraps 0xFF to 0x00, overflow
// R04: Overflow requests interrupt only when masked in
// R05: Down mode loads channel 0 value, counts down
// R06: Modulo counts 0x00 to channel 0 value
// R07: Up/down counts up then down, centre aligned
// R08: Clear resets counter and direction to up
// R09: Two independent compare channels per timer
// R10: Match sets, clears or toggles output pin
// R11: Compare outputs change without glitches
// R12: Software should prefer actions 4 or 5
// R13: Channel 0 value applies at zero, channel 1 immediately
// R14: Match sets flag, interrupt only when masked
// R15: One interrupt line per timer
// R16: One shared flag register for both timers
// R17: Flag cleared before new request; mask raises
// R18: DMA trigger pulse per channel compare
// R19: Counter value readable at any time
// R20: Software configures channel pin as output
// R21: Mode codes free, down, modulo, up/down
// R22: Prescale codes 000..111 divide 1..128
// R23: Compare action codes 000 through 110
// R24: Clear bit reads zero, writing one clears
// R25: Advance only on tick when started; reset halts
// R26: Match evaluated when enabled, one-cycle event
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module dct_top
   import dct_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [1:0] firstTimerCmpOut,
   output logic [1:0] secondTimerCmpOut,
   output logic [1:0] cmpOutEn,
   output logic firstTimerIrq,
   output logic secondTimerIrq,
   output logic firstTimerChan0DmaTrigger,
   output logic firstTimerChan1DmaTrigger,
   output logic secondTimerChan0DmaTrigger,
   output logic secondTimerChan1DmaTrigger
);

   // ********************************
   // Functions
   // ********************************
   function automatic logic [6:0] lowMask(input logic [2:0] sel);
      lowMask = 7'((8'h01 << sel) - 8'h01);
   endfunction : lowMask

   function automatic logic [7:0] regOfs(input logic [7:0] addr);
      regOfs = addr & OFS_TMR_MASK;
   endfunction : regOfs

   // ********************************
   // APB decode
   // ********************************
   logic armed_ff;
   logic [31:0] rdata_ff;
   logic [31:0] rdMux;
   logic [2:0] tickSel_ff;
   logic [FLG_W-1:0] flags_ff;
   logic [FLG_W-1:0] nxt_flags;
   logic [FLG_W-1:0] flagSet;
   logic [1:0] irq_ff;
   logic [6:0] tickDiv_ff;
   logic [6:0] pre_ff;
   logic [7:0] cntArr [2];
   logic [7:0] ctlArr [2];
   logic [7:0] cctl0Arr [2];
   logic [7:0] cctl1Arr [2];
   logic [7:0] cc0Arr [2];
   logic [7:0] cc1Arr [2];
   logic [1:0] irqTerm;
   logic [1:0] dmaCh0;
   logic [1:0] dmaCh1;
   logic [1:0] pinCh0;
   logic [1:0] pinCh1;
   logic [1:0] enCh0;
   logic [1:0] enCh1;

   wire accessOk = psel && penable && pready;
   wire wrEn = accessOk && pwrite;
   wire inTimer = paddr < OFS_FLAGS;
   wire hitFlags = paddr == OFS_FLAGS;
   wire hitClk = paddr == OFS_CLKCTL;
   wire [7:0] ofs = regOfs(paddr);
   wire ofsOk = (ofs == OFS_CNT) || (ofs == OFS_CTL) || (ofs == OFS_CCTL0) || (ofs == OFS_CC0) ||
      (ofs == OFS_CCTL1) || (ofs == OFS_CC1);
   wire addrOk = (inTimer && ofsOk) || hitFlags || hitClk;
   wire tmrSel = paddr[TMR_SEL_BIT];
   wire flagsWr = wrEn && hitFlags;
   wire clkWr = wrEn && hitClk;

   // Unmapped reads return zero; mapped read data is captured a cycle ahead of pready
   always_comb
   begin
      rdMux = 32'h0000_0000;
      if (hitFlags)
         rdMux[FLG_W-1:0] = flags_ff; // see R16
      else if (hitClk)
         rdMux[2:0] = tickSel_ff;
      else if (inTimer && ofs == OFS_CNT)
         rdMux[7:0] = cntArr[tmrSel]; // see R19
      else if (inTimer && ofs == OFS_CTL)
         rdMux[7:0] = ctlArr[tmrSel];
      else if (inTimer && ofs == OFS_CCTL0)
         rdMux[7:0] = cctl0Arr[tmrSel];
      else if (inTimer && ofs == OFS_CC0)
         rdMux[7:0] = cc0Arr[tmrSel];
      else if (inTimer && ofs == OFS_CCTL1)
         rdMux[7:0] = cctl1Arr[tmrSel];
      else if (inTimer && ofs == OFS_CC1)
         rdMux[7:0] = cc1Arr[tmrSel];
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         armed_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end
      else if (clkEn)
      begin
         armed_ff <= psel && !accessOk;
         if (psel)
            rdata_ff <= rdMux;
      end
   end

   assign pready = clkEn && penable && armed_ff;
   assign pslverr = pready && psel && !addrOk;
   assign prdata = rdata_ff;

   // ********************************
   // Tick and prescaler
   // ********************************
   // One prescaler is shared by both timers; the first step after start may come early
   wire tickPulse = (tickDiv_ff & lowMask(tickSel_ff)) == PRE_ZERO;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         tickSel_ff <= TICK_RST;
         tickDiv_ff <= PRE_ZERO;
         pre_ff <= PRE_ZERO;
      end
      else if (clkEn)
      begin
         if (clkWr)
            tickSel_ff <= pwdata[2:0];
         tickDiv_ff <= tickDiv_ff + 7'h01;
         if (tickPulse)
            pre_ff <= pre_ff + 7'h01; // see R01
      end
   end

   // ********************************
   // Timers
   // ********************************
   for (genvar i = 0; i < 2; i++)
   begin : gTmr
      logic [7:0] cnt_ff;
      logic [7:0] nxt_cnt;
      logic dir_ff;
      logic nxt_dir;
      logic upd_ff;
      logic ovf;
      logic [2:0] div_ff;
      logic start_ff;
      logic overflow_irq_mask_ff;
      logic [1:0] mode_ff;
      logic [6:0] cctl0_ff;
      logic [6:0] cctl1_ff;
      logic [7:0] cc0Shadow_ff;
      logic [7:0] cc0Act_ff;
      logic [7:0] cc1_ff;
      logic ev0;
      logic ev1;

      wire mine = inTimer && (tmrSel == 1'(i));
      wire ctlWr = wrEn && mine && ofs == OFS_CTL;
      wire startRise = ctlWr && pwdata[CTL_START_BIT] && !start_ff;
      wire clrReq = ctlWr && pwdata[CTL_CLR_BIT]; // see R24
      wire actEdge = tickPulse && ((pre_ff & lowMask(div_ff)) == PRE_ZERO); // see R22
      wire step = start_ff && actEdge; // see R25
      wire [7:0] cc0 = cc0Act_ff;

      always_comb
      begin
         nxt_cnt = cnt_ff;
         nxt_dir = dir_ff;
         ovf = 1'b0;
         if (clrReq)
         begin
            nxt_cnt = CNT_ZERO; // see R08
            nxt_dir = 1'b0;
         end
         else if (startRise && dct_mode_t'(pwdata[CTL_MODE_LSB +: 2]) == MODE_DOWN)
            nxt_cnt = cc0; // see R05
         else if (step)
            case (dct_mode_t'(mode_ff)) // see R21
               MODE_FREE:
               begin
                  nxt_cnt = cnt_ff + 8'h01; // see R03
                  ovf = cnt_ff == CNT_TOP;
               end
               MODE_DOWN:
                  if (cnt_ff == CNT_ZERO)
                     nxt_cnt = cc0;
                  else
                  begin
                     nxt_cnt = cnt_ff - 8'h01; // see R05
                     ovf = cnt_ff == CNT_ONE;
                  end
               MODE_MOD:
                  if (cnt_ff >= cc0)
                  begin
                     nxt_cnt = CNT_ZERO; // see R06
                     ovf = 1'b1;
                  end
                  else
                     nxt_cnt = cnt_ff + 8'h01;
               default:
                  if (!dir_ff)
                  begin
                     if (cnt_ff >= cc0)
                     begin
                        nxt_dir = cc0 != CNT_ZERO; // see R07
                        nxt_cnt = (cc0 == CNT_ZERO) ? CNT_ZERO : cnt_ff - 8'h01;
                     end
                     else
                        nxt_cnt = cnt_ff + 8'h01;
                  end
                  else if (cnt_ff <= CNT_ONE)
                  begin
                     nxt_cnt = CNT_ZERO; // see R07
                     nxt_dir = 1'b0;
                     ovf = cnt_ff == CNT_ONE;
                  end
                  else
                     nxt_cnt = cnt_ff - 8'h01;
            endcase
      end

      always_ff @(posedge sys_clk)
      begin
         if (srst)
         begin
            cnt_ff <= CNT_ZERO; // see R25
            dir_ff <= 1'b0;
            upd_ff <= 1'b0;
            div_ff <= DIV_RST;
            start_ff <= 1'b0;
            overflow_irq_mask_ff <= OVERFLOW_IRQ_MASK_RST;
            mode_ff <= MODE_FREE;
            cctl0_ff <= CCTL_RST;
            cctl1_ff <= CCTL_RST;
            cc0Shadow_ff <= CC_RST;
            cc0Act_ff <= CC_RST;
            cc1_ff <= CC_RST;
         end
         else if (clkEn)
         begin
            cnt_ff <= nxt_cnt; // see R02
            dir_ff <= nxt_dir;
            upd_ff <= step || clrReq || startRise;
            if (ctlWr)
            begin
               div_ff <= pwdata[CTL_DIV_LSB +: 3];
               start_ff <= pwdata[CTL_START_BIT]; // see R02
               overflow_irq_mask_ff <= pwdata[CTL_OVERFLOW_IRQ_MASK_BIT];
               mode_ff <= pwdata[CTL_MODE_LSB +: 2];
            end
            if (wrEn && mine && ofs == OFS_CCTL0)
               cctl0_ff <= pwdata[6:0];
            if (wrEn && mine && ofs == OFS_CCTL1)
               cctl1_ff <= pwdata[6:0];
            if (wrEn && mine && ofs == OFS_CC0)
               cc0Shadow_ff <= pwdata[7:0];
            if (cnt_ff == CNT_ZERO)
               cc0Act_ff <= cc0Shadow_ff; // see R13
            if (wrEn && mine && ofs == OFS_CC1)
               cc1_ff <= pwdata[7:0]; // see R13
         end
      end

      // Channel 0 and 1 share the counter but own their settings
      dct_chan uChan0 (
         .sys_clk(sys_clk),
         .srst(srst),
         .clkEn(clkEn),
         .cnt(cnt_ff),
         .cntUpd(upd_ff),
         .countDown(dir_ff),
         .updnMode(dct_mode_t'(mode_ff) == MODE_UPDN),
         .started(start_ff),
         .enable(cctl0_ff[CCTL_EN_BIT]),
         .action(cctl0_ff[CCTL_CMP_LSB +: 3]),
         .cmpVal(cc0Act_ff),
         .pinOut(pinCh0[i]),
         .matchEv(ev0)
      ); // see R09

      dct_chan uChan1 (
         .sys_clk(sys_clk),
         .srst(srst),
         .clkEn(clkEn),
         .cnt(cnt_ff),
         .cntUpd(upd_ff),
         .countDown(dir_ff),
         .updnMode(dct_mode_t'(mode_ff) == MODE_UPDN),
         .started(start_ff),
         .enable(cctl1_ff[CCTL_EN_BIT]),
         .action(cctl1_ff[CCTL_CMP_LSB +: 3]),
         .cmpVal(cc1_ff),
         .pinOut(pinCh1[i]),
         .matchEv(ev1)
      ); // see R09

      assign flagSet[i*FLG_PER_TMR +: FLG_PER_TMR] = {ev1, ev0, ovf && clkEn};
      assign dmaCh0[i] = ev0; // see R18
      assign dmaCh1[i] = ev1; // see R18
      assign enCh0[i] = cctl0_ff[CCTL_EN_BIT];
      assign enCh1[i] = cctl1_ff[CCTL_EN_BIT];
      assign irqTerm[i] = (flags_ff[i*FLG_PER_TMR+FLG_OVF] && overflow_irq_mask_ff) || // see R04
         (flags_ff[i*FLG_PER_TMR+FLG_CH0] && cctl0_ff[CCTL_IM_BIT]) || // see R14
         (flags_ff[i*FLG_PER_TMR+FLG_CH1] && cctl1_ff[CCTL_IM_BIT]);
      assign cntArr[i] = cnt_ff;
      assign ctlArr[i] = {div_ff, start_ff, overflow_irq_mask_ff, 1'b0, mode_ff}; // see R24
      assign cctl0Arr[i] = {1'b0, cctl0_ff};
      assign cctl1Arr[i] = {1'b0, cctl1_ff};
      assign cc0Arr[i] = cc0Shadow_ff;
      assign cc1Arr[i] = cc1_ff;
   end

   // ********************************
   // Shared flags and interrupt lines
   // ********************************
   // Write one to clear; a flag being set in the same cycle stays set
   assign nxt_flags = (flags_ff & ~(flagsWr ? pwdata[FLG_W-1:0] : 6'h00)) | flagSet; // see R17

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         flags_ff <= 6'h00;
         irq_ff <= 2'h0;
      end
      else if (clkEn)
      begin
         flags_ff <= nxt_flags; // see R16
         irq_ff <= irqTerm; // see R15
      end
   end

   assign firstTimerIrq = irq_ff[0];
   assign secondTimerIrq = irq_ff[1];
   assign firstTimerCmpOut = {pinCh1[0], pinCh0[0]};
   assign secondTimerCmpOut = {pinCh1[1], pinCh0[1]};
   assign cmpOutEn = {enCh1[1] || enCh0[1], enCh1[0] || enCh0[0]}; // see R20
   assign firstTimerChan0DmaTrigger = dmaCh0[0];
   assign firstTimerChan1DmaTrigger = dmaCh1[0];
   assign secondTimerChan0DmaTrigger = dmaCh0[1];
   assign secondTimerChan1DmaTrigger = dmaCh1[1];

endmodule : dct_top
`default_nettype wire

/* dct_pkg.sv */
// Package: constants, field layout and types of the dual channel 8-bit timer
package dct_pkg;

   // ********************************
   // Register byte offsets
   // ********************************
   localparam logic [7:0] OFS_CNT = 8'h00;
   localparam logic [7:0] OFS_CTL = 8'h04;
   localparam logic [7:0] OFS_CCTL0 = 8'h08;
   localparam logic [7:0] OFS_CC0 = 8'h0C;
   localparam logic [7:0] OFS_CCTL1 = 8'h10;
   localparam logic [7:0] OFS_CC1 = 8'h14;
   localparam logic [7:0] OFS_TMR_MASK = 8'h1F;
   localparam logic [7:0] OFS_FLAGS = 8'h40;
   localparam logic [7:0] OFS_CLKCTL = 8'h44;
   localparam int TMR_SEL_BIT = 5;

   // ********************************
   // Field positions
   // ********************************
   localparam int CTL_DIV_LSB = 5;
   localparam int CTL_START_BIT = 4;
   localparam int CTL_OVERFLOW_IRQ_MASK_BIT = 3;
   localparam int CTL_CLR_BIT = 2;
   localparam int CTL_MODE_LSB = 0;
   localparam int CCTL_IM_BIT = 6;
   localparam int CCTL_CMP_LSB = 3;
   localparam int CCTL_EN_BIT = 2;
   localparam int FLG_OVF = 0;
   localparam int FLG_CH0 = 1;
   localparam int FLG_CH1 = 2;
   localparam int FLG_PER_TMR = 3;
   localparam int FLG_W = 6;

   // ********************************
   // Reset values and counter limits
   // ********************************
   localparam logic [2:0] DIV_RST = 3'h0;
   localparam logic OVERFLOW_IRQ_MASK_RST = 1'b1;
   localparam logic [6:0] CCTL_RST = 7'h40;
   localparam logic [7:0] CC_RST = 8'h00;
   localparam logic [2:0] TICK_RST = 3'h0;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [7:0] CNT_TOP = 8'hFF;
   localparam logic [6:0] PRE_ZERO = 7'h00;

   // ********************************
   // Types
   // ********************************
   typedef enum logic [1:0] {MODE_FREE = 2'b00, MODE_DOWN = 2'b01, MODE_MOD = 2'b10, MODE_UPDN = 2'b11} dct_mode_t;
   typedef enum logic [2:0] {
      ACT_SET = 3'h0, ACT_CLR = 3'h1, ACT_TGL = 3'h2, ACT_SET_UP = 3'h3,
      ACT_CLR_UP = 3'h4, ACT_SET_TOP = 3'h5, ACT_CLR_ZERO = 3'h6, ACT_NONE = 3'h7
   } dct_action_t;

endpackage : dct_pkg

/* dct_chan.sv */
// Module: one output compare channel with its glitch-free output flop
`timescale 1ns/100ps
`default_nettype none
module dct_chan
   import dct_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clkEn,
   input wire logic [7:0] cnt,
   input wire logic cntUpd,
   input wire logic countDown,
   input wire logic updnMode,
   input wire logic started,
   input wire logic enable,
   input wire logic [2:0] action,
   input wire logic [7:0] cmpVal,
   output logic pinOut,
   output logic matchEv
);

   logic pin_ff;
   logic match_ff;
   logic nxt_pin;
   wire hit = cntUpd && started && enable && (cnt == cmpVal);
   wire atZero = cntUpd && started && enable && (cnt == CNT_ZERO);
   wire atTop = cntUpd && started && enable && (cnt == CNT_TOP);

   // ********************************
   // Output action
   // ********************************
   // Output only ever changes on a clock edge, so no decode glitch reaches the pin
   always_comb
   begin
      nxt_pin = pin_ff;
      case (dct_action_t'(action))
         ACT_SET: if (hit) nxt_pin = 1'b1; // see R10
         ACT_CLR: if (hit) nxt_pin = 1'b0; // see R10
         ACT_TGL: if (hit) nxt_pin = ~pin_ff; // see R10
         ACT_SET_UP:
            if (hit) nxt_pin = ~(updnMode && countDown); // see R23
            else if (atZero && !updnMode) nxt_pin = 1'b0;
         ACT_CLR_UP:
            if (hit) nxt_pin = updnMode && countDown; // see R23
            else if (atZero && !updnMode) nxt_pin = 1'b1;
         ACT_SET_TOP:
            if (hit) nxt_pin = 1'b1; // see R23
            else if (atTop) nxt_pin = 1'b0;
         ACT_CLR_ZERO:
            if (hit) nxt_pin = 1'b0; // see R23
            else if (atZero) nxt_pin = 1'b1;
         default: nxt_pin = pin_ff;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         pin_ff <= 1'b0;
         match_ff <= 1'b0;
      end
      else if (clkEn)
      begin
         pin_ff <= nxt_pin; // see R11
         match_ff <= hit; // see R26
      end
   end

   assign pinOut = pin_ff;
   assign matchEv = match_ff;

endmodule : dct_chan
`default_nettype wire

/* dct_sys_model.sv */
// Model of the DMA controller that counts the timer compare triggers
`timescale 1ns/100ps
`default_nettype none
module dct_sys_model
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [3:0] dma,
   output logic [3:0][7:0] dmaCnt
);
   // ********************************
   // Trigger counters
   // ********************************
   // Counts every high cycle, so a stretched pulse shows up as extra triggers
   always_ff @(posedge sys_clk)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (srst)
            dmaCnt[i] <= 8'h00;
         else if (dma[i])
            dmaCnt[i] <= dmaCnt[i] + 8'h01;
      end
   end
endmodule : dct_sys_model
`default_nettype wire

/* dct_top_assertions.sv */
// Checker of the timer ports
`timescale 1ns/100ps
`default_nettype none
module dct_top_assertions
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] firstTimerCmpOut,
   input wire logic [1:0] secondTimerCmpOut,
   input wire logic [1:0] cmpOutEn,
   input wire logic firstTimerIrq,
   input wire logic secondTimerIrq,
   input wire logic firstTimerChan0DmaTrigger,
   input wire logic firstTimerChan1DmaTrigger,
   input wire logic secondTimerChan0DmaTrigger,
   input wire logic secondTimerChan1DmaTrigger
);
   // ********************************
   // Properties
   // ********************************
   default clocking cb @(posedge sys_clk);
   endclocking
   sequence s_setup;
      psel && !penable && clkEn;
   endsequence
   sequence s_access;
      psel && penable && clkEn;
   endsequence
   property p_pulse(logic s);
      disable iff (srst) s |=> !s;
   endproperty
   a_ready_in_access: assert property (disable iff (srst) pready |-> psel && penable)
      else $error("ready outside access");
   a_ready_needs_en: assert property (disable iff (srst) pready |-> clkEn)
      else $error("ready while frozen");
   a_zero_wait: assert property (disable iff (srst) s_setup ##1 s_access |-> pready)
      else $error("access not answered at once");
   a_err_with_ready: assert property (disable iff (srst) pslverr |-> pready)
      else $error("error without ready");
   a_err_reads_zero: assert property (disable iff (srst) pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_pulse_a0: assert property (p_pulse(firstTimerChan0DmaTrigger))
      else $error("trigger longer than a cycle");
   a_pulse_a1: assert property (p_pulse(firstTimerChan1DmaTrigger))
      else $error("trigger longer than a cycle");
   a_pulse_b0: assert property (p_pulse(secondTimerChan0DmaTrigger))
      else $error("trigger longer than a cycle");
   a_pulse_b1: assert property (p_pulse(secondTimerChan1DmaTrigger))
      else $error("trigger longer than a cycle");
   a_reset_quiet: assert property (srst |=> firstTimerCmpOut == 2'b00 && secondTimerCmpOut == 2'b00 &&
      !firstTimerIrq && !secondTimerIrq && !firstTimerChan1DmaTrigger)
      else $error("outputs active after reset");
endmodule : dct_top_assertions
bind dct_top dct_top_assertions i_chk (.sys_clk, .srst, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .firstTimerCmpOut, .secondTimerCmpOut, .cmpOutEn, .firstTimerIrq,
   .secondTimerIrq, .firstTimerChan0DmaTrigger, .firstTimerChan1DmaTrigger, .secondTimerChan0DmaTrigger,
   .secondTimerChan1DmaTrigger);
`default_nettype wire

/* dual_channel_8bit_timer_tb.sv */
// Testbench of the dual channel 8-bit timer
`timescale 1ns/100ps
`default_nettype none
module dual_channel_8bit_timer_tb
   import dct_pkg::*;
;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic clkEn = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [1:0] outA;
   logic [1:0] outB;
   logic [1:0] outEn;
   logic irqA;
   logic irqB;
   logic [3:0] dma;
   logic [3:0][7:0] dmaCnt;
   logic [31:0] seed = 32'h74A5;
   logic [31:0] rd;
   logic [31:0] c0;
   logic [7:0] cc;
   logic err;
   logic prev;
   int bad_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int capCyc;
   int t0;
   logic [7:0] rstAddr [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h24, 8'h40, 8'h44};
   logic [7:0] rstExp [9] = '{8'h00, 8'h08, 8'h40, 8'h00, 8'h40, 8'h00, 8'h08, 8'h00, 8'h00};
   dct_action_t acts [3] = '{ACT_SET, ACT_CLR, ACT_TGL};

   dct_top i_dut (.sys_clk, .srst, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .firstTimerCmpOut(outA), .secondTimerCmpOut(outB), .cmpOutEn(outEn), .firstTimerIrq(irqA),
      .secondTimerIrq(irqB), .firstTimerChan0DmaTrigger(dma[0]), .firstTimerChan1DmaTrigger(dma[1]),
      .secondTimerChan0DmaTrigger(dma[2]), .secondTimerChan1DmaTrigger(dma[3]));
   dct_sys_model i_sys (.sys_clk, .srst, .dma, .dmaCnt);

   always #50 sys_clk = ~sys_clk;
   // Generous ceiling: the sequence needs well under 8000 cycles
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         bad_count++;
         results();
      end
   end

   // ********************************
   // Helpers
   // ********************************
   function automatic logic [31:0] nextRand();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : nextRand
   function automatic logic [31:0] ctl(input logic [2:0] dv, input logic st, im, cl, input logic [1:0] md);
      return {24'h0, dv, st, im, cl, md};
   endfunction : ctl
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Entered right after a rising edge; one idle cycle follows each transfer
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      capCyc = cyc;
      @(posedge sys_clk);
      while (pready !== 1'b1 && n < 50)
      begin
         n++;
         @(posedge sys_clk);
      end
      chk(n < 50, 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   task automatic waitDma(input int ch);
      logic [7:0] n0;
      int k;
      n0 = dmaCnt[ch];
      k = 0;
      while (dmaCnt[ch] === n0 && k < 600)
      begin
         k++;
         @(posedge sys_clk);
      end
      @(posedge sys_clk);
      chk(k < 600, 1'b1);
   endtask : waitDma
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results

   // ********************************
   // Main sequence
   // ********************************
   initial
   begin
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      foreach (rstAddr[i])
      begin
         apb(1'b0, rstAddr[i], 32'h0);
         chk(rd, {24'h0, rstExp[i]});
      end
      apb(1'b0, 8'h18, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      $display("test reset done");
      // Free running overflow, masks and flag clearing
      apb(1'b1, 8'h04, ctl(3'h0, 1'b1, 1'b1, 1'b0, MODE_FREE));
      repeat (270) @(posedge sys_clk);
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h1);
      chk({irqA, irqB}, 2'b10);
      // Freeze: a low clock enable must hold the running counter
      apb(1'b0, 8'h00, 32'h0);
      c0 = rd;
      t0 = capCyc;
      clkEn <= 1'b0;
      repeat (50) @(posedge sys_clk);
      clkEn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      chk(8'(rd - c0), 8'(capCyc - t0 - 50));
      apb(1'b1, 8'h04, ctl(3'h0, 1'b0, 1'b0, 1'b0, MODE_FREE));
      apb(1'b0, 8'h00, 32'h0);
      c0 = rd;
      repeat (20) @(posedge sys_clk);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, c0);
      chk(irqA, 1'b0);
      apb(1'b1, 8'h04, ctl(3'h0, 1'b0, 1'b1, 1'b0, MODE_FREE));
      repeat (2) @(posedge sys_clk);
      chk(irqA, 1'b1);
      apb(1'b1, 8'h40, 32'h1);
      repeat (2) @(posedge sys_clk);
      chk(irqA, 1'b0);
      apb(1'b1, 8'h04, ctl(3'h0, 1'b0, 1'b1, 1'b1, MODE_FREE));
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h08);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      $display("test free running done");
      // Prescaler: step count over a span, phase of the shared prescaler unknown
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, 8'h44, (i == 3));
         apb(1'b1, 8'h04, ctl(i, 1'b1, 1'b1, 1'b0, MODE_FREE));
         apb(1'b0, 8'h00, 32'h0);
         c0 = rd;
         t0 = capCyc;
         repeat (100) @(posedge sys_clk);
         apb(1'b0, 8'h00, 32'h0);
         t0 = ((capCyc - t0) >> (i + (i == 3))) - int'(rd[7:0] - c0[7:0]);
         chk(t0 >= -1 && t0 <= 1, 1'b1);
         apb(1'b1, 8'h04, ctl(3'h0, 1'b0, 1'b1, 1'b1, MODE_FREE));
      end
      apb(1'b1, 8'h44, 32'h0);
      $display("test prescaler done");
      // Modulo, down and up/down with random compare values
      for (int k = 0; k < 4; k++)
      begin
         cc = (nextRand() & 8'h1F) | 8'h04;
         apb(1'b1, 8'h0C, cc);
         apb(1'b1, 8'h40, 32'h3F);
         apb(1'b1, 8'h04, ctl(3'h0, 1'b1, 1'b1, 1'b0, (k == 0) ? MODE_MOD : 2'(k)));
         for (int j = 0; j < 24; j++)
         begin
            apb(1'b0, 8'h00, 32'h0);
            chk(rd[7:0] <= cc, 1'b1);
         end
         apb(1'b0, 8'h40, 32'h0);
         chk(rd, 32'h1);
         apb(1'b0, 8'h0C, 32'h0);
         chk(rd, cc);
         apb(1'b1, 8'h04, ctl(3'h0, 1'b0, 1'b1, 1'b1, MODE_FREE));
      end
      $display("test modulo done");
      // Channel 1 compare actions in free running mode
      apb(1'b1, 8'h14, 32'h20);
      apb(1'b1, 8'h40, 32'h3F);
      apb(1'b1, 8'h04, ctl(3'h0, 1'b1, 1'b1, 1'b0, MODE_FREE));
      foreach (acts[i])
      begin
         apb(1'b1, 8'h10, {25'h0, 1'b1, acts[i], 1'b1, 2'b00});
         waitDma(1);
         prev = outA[1];
         waitDma(1);
         chk(outA[1], (acts[i] == ACT_SET) ? 1'b1 : (acts[i] == ACT_CLR) ? 1'b0 : !prev);
      end
      // Simple PWM: set on match, clear at the top of the count
      apb(1'b1, 8'h10, {25'h0, 1'b1, ACT_SET_TOP, 1'b1, 2'b00});
      waitDma(1);
      chk(outA[1], 1'b1);
      repeat (230) @(posedge sys_clk);
      chk(outA[1], 1'b0);
      chk(outEn, 2'b01);
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h5);
      chk({outB, dmaCnt[0], dmaCnt[2], dmaCnt[3]}, 26'h0);
      $display("test compare done");
      results();
   end
endmodule : dual_channel_8bit_timer_tb
`default_nettype wire
